// ### core/pds_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Power domain sequencer top: controller plus six policy units.
// ****************************************************************
module pds_sequencer #(
  parameter int NDOM = pds_pkg::NUM_DOMAINS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] MODE_SEL,
  input wire logic WAKE_EVT,
  input wire logic [5:0] SW_DOM_ALLOW,
  input wire logic [5:0] DOM_COND_OK,
  input wire logic [5:0] SW_CLK_ALLOW,
  output logic [5:0] DOM_PWR_EN,
  output logic [5:0] DOM_CLK_EN,
  output logic [2:0] CUR_MODE,
  output logic BUSY,
  output logic TRUST_CORE_RUN,
  output logic CORE_CLK_EN
);
  typedef enum logic [5:0] {
    S_BOOT_EFF = 6'h01,
    S_BOOT_REST = 6'h02,
    S_STEADY = 6'h04,
    S_MOVE = 6'h08,
    S_WARM_TRUST = 6'h10,
    S_WARM_RT = 6'h20
  } pds_state_t;

  typedef struct packed {
    pds_state_t fsm;
    logic [5:0] pwr_req;
    logic [5:0] clk_req;
    logic [2:0] mode;
    logic [2:0] target;
    logic warm;
  } pds_top_state_t;

  pds_top_state_t st_reg, st_next;
  logic [5:0] pwr_ack, clk_ack;
  logic all_ack;
  logic [5:0] want_doms;
  logic want_clk;
  logic [5:0] want_clks;
  logic [2:0] sel_mode;

  // ****************************************************************
  // Six policy units, one per domain.
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NDOM; g++)
    begin : g_dom
      pds_ctl_if ctl ();
      assign ctl.pwr_req = st_reg.pwr_req[g];
      assign ctl.clk_req = st_reg.clk_req[g];
      assign pwr_ack[g] = ctl.pwr_ack;
      assign clk_ack[g] = ctl.clk_ack;
      // Domain 0 is the battery domain and never switches off.
      pds_policy_unit #(.ALWAYS_ON(g == pds_pkg::DOM_BATTERY)) u_pu (
        .clk(CLK),
        .rst(RST),
        .ctl(ctl),
        .sw_allow(SW_DOM_ALLOW[g] | (g == pds_pkg::DOM_EFF_CTRL)),
        .cond_ok(DOM_COND_OK[g]),
        .sw_pwr_ok(SW_CLK_ALLOW[g]),
        .pwr_en(DOM_PWR_EN[g]),
        .clk_en(DOM_CLK_EN[g])
      );
    end
  endgenerate

  assign all_ack = &pwr_ack & &clk_ack;

  // Mode table; the realtime domain carries the efficiency core.
  function automatic logic [5:0] doms_of(input logic [2:0] m);
    logic [5:0] d;
    d = pds_pkg::DOMS_AON_ONLY;
    if (m == pds_pkg::PDS_FULL_RUN) d = pds_pkg::DOMS_FULL_RUN;
    else if (m == pds_pkg::PDS_CLK_GATED) d = pds_pkg::DOMS_CLK_GATED;
    else if (m == pds_pkg::PDS_CORE_OFF) d = pds_pkg::DOMS_CORE_OFF;
    else if (m == pds_pkg::PDS_LOW_PERIPH) d = pds_pkg::DOMS_LOW_PERIPH;
    else d = pds_pkg::DOMS_AON_ONLY;
    return d;
  endfunction

  // Unknown mode codes fall back to the lowest mode, which is always safe.
  assign want_doms = doms_of(st_reg.target);
  assign want_clk = (st_reg.target == pds_pkg::PDS_FULL_RUN);
  // Clocks follow power, except the core clock outside full run.
  assign want_clks = want_doms & ~(want_clk ? 6'h00 : 6'h04);
  // Codes above the lowest mode are stored as the lowest mode, so the reported mode is always a real one.
  assign sel_mode = (MODE_SEL > pds_pkg::PDS_AON_ONLY) ? pds_pkg::PDS_AON_ONLY : MODE_SEL;

  // ****************************************************************
  // Sequence controller. Software only picks the mode; all domain
  // steps happen here without further software action.
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    case (st_reg.fsm)
      S_BOOT_EFF:
      begin
        // Efficiency control domain first, nothing else yet.
        st_next.pwr_req = pds_pkg::RESET_DOMS | 6'h02;
        st_next.clk_req = 6'h00;
        if (all_ack && st_reg.pwr_req[pds_pkg::DOM_EFF_CTRL])
        begin
          st_next.fsm = st_reg.warm ? S_WARM_TRUST : S_BOOT_REST;
        end
      end
      S_BOOT_REST:
      begin
        // Cold boot: the requested mode's domains all at once, efficiency control kept on.
        st_next.pwr_req = want_doms | pds_pkg::RESET_DOMS | 6'h02;
        st_next.clk_req = want_clks;
        st_next.fsm = S_MOVE;
      end
      S_WARM_TRUST:
      begin
        // Warm wake: enclave domain before the realtime domain.
        st_next.pwr_req = pds_pkg::RESET_DOMS | 6'h02 | 6'h08;
        st_next.clk_req = 6'h08;
        if (all_ack && st_reg.pwr_req[pds_pkg::DOM_ENCLAVE])
        begin
          st_next.fsm = S_WARM_RT;
        end
      end
      S_WARM_RT:
      begin
        st_next.pwr_req = want_doms | st_reg.pwr_req | 6'h04;
        st_next.clk_req = want_clks;
        st_next.fsm = S_MOVE;
      end
      S_MOVE:
      begin
        st_next.pwr_req = want_doms;
        st_next.clk_req = want_clks;
        // Clock requests must have settled too, or a gated mode would be reported early.
        if (all_ack && st_reg.pwr_req == want_doms && st_reg.clk_req == want_clks)
        begin
          st_next.mode = st_reg.target;
          st_next.fsm = S_STEADY;
        end
      end
      S_STEADY:
      begin
        if (WAKE_EVT && st_reg.mode == pds_pkg::PDS_AON_ONLY)
        begin
          st_next.warm = 1'b1;
          st_next.target = sel_mode;
          st_next.fsm = S_BOOT_EFF;
        end
        else if (sel_mode != st_reg.mode)
        begin
          st_next.target = sel_mode;
          st_next.warm = 1'b0;
          // Leaving always-on only is a power-up, so it takes the cold boot order.
          if (st_reg.mode == pds_pkg::PDS_AON_ONLY)
          begin
            st_next.fsm = S_BOOT_EFF;
          end
          else
          begin
            st_next.fsm = S_MOVE;
          end
        end
      end
      default:
      begin
        st_next.fsm = S_BOOT_EFF;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      // Held here throughout the supply ramp.
      st_reg.fsm <= S_BOOT_EFF;
      st_reg.pwr_req <= pds_pkg::RESET_DOMS;
      st_reg.clk_req <= 6'h00;
      st_reg.mode <= pds_pkg::PDS_AON_ONLY;
      st_reg.target <= pds_pkg::PDS_FULL_RUN;
      st_reg.warm <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign CUR_MODE = st_reg.mode;
  assign BUSY = (st_reg.fsm != S_STEADY);
  assign TRUST_CORE_RUN = DOM_CLK_EN[pds_pkg::DOM_ENCLAVE];
  assign CORE_CLK_EN = DOM_CLK_EN[pds_pkg::DOM_RT_SUBSYS];

  // ****************************************************************
  // Checks.
  // ****************************************************************
  sequence warm_start_s;
    st_reg.fsm == S_WARM_TRUST;
  endsequence

  batt_on_a: assert property (@(posedge CLK) disable iff (RST) DOM_PWR_EN[0])
    else $error("Battery domain unpowered.");
  eff_first_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(DOM_PWR_EN[2]) |-> DOM_PWR_EN[1])
    else $error("Domain rose before efficiency control.");
  trust_first_a: assert property (@(posedge CLK) disable iff (RST)
    warm_start_s |-> !st_reg.pwr_req[2])
    else $error("Realtime requested before trust core.");
  mode_ack_a: assert property (@(posedge CLK) disable iff (RST)
    $changed(st_reg.mode) |-> $past(all_ack))
    else $error("Mode changed without acknowledge.");
  aon_only_a: assert property (@(posedge CLK) disable iff (RST)
    (!BUSY && CUR_MODE == pds_pkg::PDS_AON_ONLY) |-> (DOM_PWR_EN[5:1] == 5'h00))
    else $error("Domain on in always-on only mode.");
  gated_clk_a: assert property (@(posedge CLK) disable iff (RST)
    (!BUSY && CUR_MODE == pds_pkg::PDS_CLK_GATED) |-> !CORE_CLK_EN)
    else $error("Core clock runs in gated mode.");
  core_off_a: assert property (@(posedge CLK) disable iff (RST)
    (!BUSY && CUR_MODE >= pds_pkg::PDS_CORE_OFF) |-> !DOM_PWR_EN[2])
    else $error("Core powered in off mode.");
  move_bound_a: assert property (@(posedge CLK) disable iff (RST)
    (st_reg.fsm == S_STEADY && sel_mode != st_reg.mode && !WAKE_EVT)
    |=> st_reg.fsm == ((st_reg.mode == pds_pkg::PDS_AON_ONLY) ? S_BOOT_EFF : S_MOVE))
    else $error("Controller ignored mode request.");
endmodule // pds_sequencer
`default_nettype wire

// ### core/pds_pkg.sv
// Summary of operation
// - Six domains, each with its own controller.
// - Top state machine switches domains from inputs.
// - Policy unit merges command, status, configuration.
// - Battery domain and always-on region stay powered.
// - Efficiency control domain powers up first.
// - Remaining order depends on cold or warm.
// - Domains grouped into three regions.
// - Five power modes, highest to lowest consumption.
// - Full run: core powered and clocked.
// - Clock gated: core powered, clock off.
// - Core off: core unpowered, some peripherals run.
// - Low peripheral: only low-power peripherals run.
// - Always-on only: all other domains off.
// - Software sets policy, hardware does transitions.
// - Warm wake brings trust core before realtime.
// - Power-on reset holds everything during ramp.
`default_nettype none
package pds_pkg;
  // ****************************************************************
  // Domain indices and region grouping.
  // ****************************************************************
  localparam int NUM_DOMAINS = 6;
  localparam int DOM_BATTERY = 0;
  localparam int DOM_EFF_CTRL = 1;
  localparam int DOM_RT_SUBSYS = 2;
  localparam int DOM_ENCLAVE = 3;
  localparam int DOM_SHARED = 4;
  localparam int DOM_DEBUG = 5;
  localparam logic [5:0] REGION_AON_MASK = 6'h01;
  localparam logic [5:0] REGION_EFF_MASK = 6'h06;
  localparam logic [5:0] REGION_PERF_MASK = 6'h38;

  // ****************************************************************
  // Device power modes, highest consumption first.
  // ****************************************************************
  typedef enum logic [2:0] {
    PDS_FULL_RUN = 3'h0,
    PDS_CLK_GATED = 3'h1,
    PDS_CORE_OFF = 3'h2,
    PDS_LOW_PERIPH = 3'h3,
    PDS_AON_ONLY = 3'h4
  } pds_mode_t;

  // Domains wanted on in each mode; the core clock is not encoded here.
  localparam logic [5:0] DOMS_FULL_RUN = 6'h3f;
  localparam logic [5:0] DOMS_CLK_GATED = 6'h3f;
  localparam logic [5:0] DOMS_CORE_OFF = 6'h33;
  localparam logic [5:0] DOMS_LOW_PERIPH = 6'h03;
  localparam logic [5:0] DOMS_AON_ONLY = 6'h01;
  localparam logic [5:0] RESET_DOMS = 6'h01;
  localparam logic [5:0] RESET_ACKS = 6'h01;
endpackage : pds_pkg
`default_nettype wire

// ### core/pds_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
// Command and acknowledge bundle between the controller and one policy unit.
interface pds_ctl_if;
  logic pwr_req;
  logic clk_req;
  logic pwr_ack;
  logic clk_ack;
  modport ctrl (output pwr_req, output clk_req, input pwr_ack, input clk_ack);
  modport unit (input pwr_req, input clk_req, output pwr_ack, output clk_ack);
endinterface : pds_ctl_if
`default_nettype wire

// ### core/pds_policy_unit.sv
`timescale 1ns/1ps
`default_nettype none
// One domain_policy_unit: drives the switch and clock of one domain.
module pds_policy_unit #(
  parameter bit ALWAYS_ON = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  pds_ctl_if.unit ctl,
  input wire logic sw_allow,
  input wire logic cond_ok,
  input wire logic sw_pwr_ok,
  output logic pwr_en,
  output logic clk_en
);
  typedef struct packed {
    logic pwr;
    logic clk;
  } pds_pu_state_t;
  pds_pu_state_t st_reg, st_next;

  // Power follows the command only when software policy and device status allow it.
  always_comb
  begin
    st_next = st_reg;
    st_next.pwr = ALWAYS_ON | (ctl.pwr_req & sw_allow & cond_ok);
    st_next.clk = st_next.pwr & ctl.clk_req & st_reg.pwr & sw_pwr_ok;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '{pwr: ALWAYS_ON, clk: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pwr_en = st_reg.pwr;
  assign clk_en = st_reg.clk;
  // Acknowledge when the reached state matches the request.
  assign ctl.pwr_ack = (st_reg.pwr == (ctl.pwr_req | ALWAYS_ON));
  assign ctl.clk_ack = (st_reg.clk == (ctl.clk_req & (ctl.pwr_req | ALWAYS_ON)));

  aon_stays_a: assert property (@(posedge clk) disable iff (rst) ALWAYS_ON |-> pwr_en)
    else $error("Always-on domain lost power.");
  clk_needs_pwr_a: assert property (@(posedge clk) disable iff (rst) clk_en |-> pwr_en)
    else $error("Clock running on unpowered domain.");
endmodule // pds_policy_unit
`default_nettype wire

// ### tb/pds_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: software policy settings, domain health status and clock permissions.
module pds_far_model (
  input wire logic [5:0] deny,
  input wire logic [5:0] fault,
  input wire logic [5:0] clk_deny,
  output logic [5:0] allow,
  output logic [5:0] clk_allow,
  output logic [5:0] cond_ok
);
  // Software only states policy and never steps a transition itself.
  assign allow = ~deny;
  // Clock permission is a separate policy, so it can be withdrawn while power stays.
  assign clk_allow = ~clk_deny;
  // A faulted domain never reports good, so the sequencer must hold off.
  assign cond_ok = ~fault;
endmodule // pds_far_model
`default_nettype wire

// ### tb/power_domain_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_domain_sequencer_bench;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [2:0] MODE_SEL = 3'h0;
  logic WAKE_EVT = 1'b0;
  logic [5:0] deny = 6'h00;
  logic [5:0] fault = 6'h00;
  logic [5:0] clk_deny = 6'h00;
  logic [5:0] allow, clk_allow, cond_ok, DOM_PWR_EN, DOM_CLK_EN;
  logic [2:0] CUR_MODE;
  logic BUSY, TRUST_CORE_RUN, CORE_CLK_EN;
  logic [5:0] prev_pwr = 6'h01;
  logic prev_trust = 1'b0;
  logic warm = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'h5956;
  int i;

  pds_far_model pds_far_model_inst (.deny(deny), .fault(fault), .clk_deny(clk_deny), .allow(allow),
    .clk_allow(clk_allow),
    .cond_ok(cond_ok));
  pds_sequencer pds_sequencer_inst (.CLK(CLK), .RST(RST), .MODE_SEL(MODE_SEL), .WAKE_EVT(WAKE_EVT),
    .SW_DOM_ALLOW(allow), .DOM_COND_OK(cond_ok), .SW_CLK_ALLOW(clk_allow), .DOM_PWR_EN(DOM_PWR_EN),
    .DOM_CLK_EN(DOM_CLK_EN), .CUR_MODE(CUR_MODE), .BUSY(BUSY), .TRUST_CORE_RUN(TRUST_CORE_RUN),
    .CORE_CLK_EN(CORE_CLK_EN));

  // The 200 MHz clock.
  initial
  begin
    forever #2.5 CLK = ~CLK;
  end

  // ****************************************************************
  // Reference model and checking helpers.
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Domains that each mode keeps powered; codes above four alias the lowest mode.
  function automatic logic [5:0] mask_of(input logic [2:0] m);
    case (m)
      3'h0, 3'h1: return 6'h3f;
      3'h2: return 6'h33;
      3'h3: return 6'h03;
      default: return 6'h01;
    endcase
  endfunction

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Request a mode, optionally with a wake event, and compare the settled state.
  task automatic go(input logic [2:0] m, input logic w);
    int n;
    logic [5:0] mk;
    n = 0;
    mk = mask_of(m);
    @(posedge CLK) #1 MODE_SEL = m;
    WAKE_EVT = w;
    warm = w;
    repeat (3) @(posedge CLK);
    // Look at BUSY one step after the edge, once it has settled.
    #1;
    while (BUSY !== 1'b0 && n < 300)
    begin
      @(posedge CLK) #1;
      n++;
    end
    WAKE_EVT = 1'b0;
    warm = 1'b0;
    chk({7'h0, BUSY}, 8'h00);
    chk({5'h0, CUR_MODE}, (m > 3'h3) ? 8'h04 : {5'h0, m});
    chk({2'h0, DOM_PWR_EN}, {2'h0, mk});
    chk({7'h0, CORE_CLK_EN}, {7'h0, m == 3'h0});
    chk({5'h0, DOM_CLK_EN[5:3]}, {5'h0, mk[5:3]});
    chk({7'h0, TRUST_CORE_RUN}, {7'h0, m < 3'h2});
  endtask

  // Every-cycle watch of power-up order, the battery domain and the hang limit.
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles > 2)
    begin
      if (!RST && ((DOM_PWR_EN & ~prev_pwr & 6'h3c) != 6'h00)) chk({7'h0, prev_pwr[1]}, 8'h01);
      if (warm && DOM_PWR_EN[2] && !prev_pwr[2]) chk({7'h0, prev_trust}, 8'h01);
      chk({7'h0, DOM_PWR_EN[0]}, 8'h01);
    end
    prev_pwr = DOM_PWR_EN;
    prev_trust = TRUST_CORE_RUN;
    if (cycles == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge CLK);
    #1 RST = 1'b0;
    go(3'h0, 1'b0);
    for (i = 1; i < 8; i++) go(i[2:0], 1'b0);
    for (i = 0; i < 12; i++) go(3'($random(seed)), 1'b0);
    // A wake only counts from always-on only, so settle there first.
    go(3'h4, 1'b0);
    go(3'h0, 1'b1);
    go(3'h4, 1'b0);
    go(3'h0, 1'b1);
    // Withheld policy on debug and a fault on shared: the move must stall, not finish.
    deny = 6'h20;
    fault = 6'h10;
    @(posedge CLK) #1 MODE_SEL = 3'h2;
    repeat (60) @(posedge CLK);
    #1 chk({6'h0, DOM_PWR_EN[4], BUSY}, 8'h01);
    // A reset in mid-transition must return everything to the reset state.
    RST = 1'b1;
    repeat (2) @(posedge CLK);
    #1 chk({DOM_PWR_EN, BUSY, 1'b0}, 8'h06);
    chk({2'h0, DOM_CLK_EN}, 8'h00);
    chk({5'h0, CUR_MODE}, 8'h04);
    deny = 6'h00;
    fault = 6'h00;
    RST = 1'b0;
    go(3'h0, 1'b0);
    // Software withdraws the enclave clock: the domain stays powered but its clock stops.
    clk_deny = 6'h08;
    repeat (3) @(posedge CLK);
    #1 chk({6'h0, DOM_PWR_EN[3], TRUST_CORE_RUN}, 8'h02);
    finish_test();
  end
endmodule // power_domain_sequencer_bench
`default_nettype wire
